// *** mrx_assertions.sv ***
// checker: bus timing and option decode of the receive word block
`timescale 1ns/1ns
module mrx_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       rx_enable,
  input wire logic       tone_detect_mode,
  input wire logic       answer_mode,
  input wire logic       descr_on,
  input wire logic       irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_off_idle: assert property (wr_stb && addr == 4'h0
    && wdata[3:0] == 4'h0 |-> ##2 !rx_enable && !tone_detect_mode)
    else $error("off mode");
  a_tone_excl: assert property (tone_detect_mode |-> !rx_enable)
    else $error("tone mode with data receive");
  a_mode_read: assert property (rd_stb && addr == 4'h9
    |=> rdata <= 8'h08) else $error("mode readback range");
  a_sts_mark: assert property (rd_stb && addr == 4'h3
    |=> rdata[0]) else $error("receive mark missing");
  a_orig_opt: assert property (wr_stb && addr == 4'h0
    |-> ##2 answer_mode == $past(wdata[7], 2)) else $error("orig bit");
  a_descr_opt: assert property (wr_stb && addr == 4'h1
    |-> ##2 descr_on == $past(wdata[5], 2)) else $error("descr bit");
  a_irq_mask: assert property (wr_stb && addr == 4'h7 && wdata == 8'h00
    |=> !irq) else $error("irq not masked");
  a_unmap_rd: assert property (rd_stb && addr > 4'h9
    |=> rdata == 8'h00) else $error("unmapped read data");
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  // main scenarios reached
  c_tone: cover property (wr_stb && addr == 4'h0 && wdata[3:0] == 4'h7);
  c_irq: cover property (irq);
  c_rx: cover property (rx_enable);
endmodule // mrx_checker

bind mrx_top mrx_checker chk_u (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .rx_enable(rx_enable), .tone_detect_mode(tone_detect_mode),
  .answer_mode(answer_mode), .descr_on(descr_on), .irq(irq)
);

// *** mrx_host_model.sv ***
// host model: register bus master for the receive word block
`timescale 1ns/1ns
module mrx_host_model (
  input  wire logic       ref_clk,
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_stb,
  output logic            rd_stb,
  input  wire logic [7:0] rdata
);
  // bus idle at time zero
  initial
  begin
    addr = 4'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // reserved bits cleared unless a test breaks the rule on purpose
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic raw);
    logic [7:0] m;
    m = (a == 4'h1) ? 8'h5f : (a == 4'h2) ? 8'hfe : 8'h00;
    @(posedge ref_clk);
    addr <= a;
    wdata <= raw ? d : d & ~m;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    addr <= ~a; // released lines do not keep the last value
    wdata <= ~d;
  endtask
  // read data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule // mrx_host_model

// *** mrx_mode_dec.sv ***
// receive mode field decoder
`timescale 1ns/1ns
module mrx_mode_dec (
  input  wire logic [3:0]           mode_code,
  output mrx_pkg::mrx_std_type      std,
  output logic                      is_psk,
  output logic                      is_fsk,
  output logic                      is_tone
);
  // map the four-bit code onto a standard; codes 8..f are unassigned
  always_comb
  begin
    case (mode_code)
      mrx_pkg::MODE_OFF:  std = mrx_pkg::MRX_OFF;
      mrx_pkg::MODE_V22B: std = mrx_pkg::MRX_V22B;
      mrx_pkg::MODE_V22:  std = mrx_pkg::MRX_V22;
      mrx_pkg::MODE_B212: std = mrx_pkg::MRX_B212;
      mrx_pkg::MODE_V23:  std = mrx_pkg::MRX_V23;
      mrx_pkg::MODE_V21:  std = mrx_pkg::MRX_V21;
      mrx_pkg::MODE_B103: std = mrx_pkg::MRX_B103;
      mrx_pkg::MODE_TONE: std = mrx_pkg::MRX_TONE;
      default:            std = mrx_pkg::MRX_BAD;
    endcase
  end

  // group the standards by how their status bytes are laid out
  always_comb
  begin
    is_psk  = (std == mrx_pkg::MRX_V22B) || (std == mrx_pkg::MRX_V22)
              || (std == mrx_pkg::MRX_B212);
    is_fsk  = (std == mrx_pkg::MRX_V23) || (std == mrx_pkg::MRX_V21)
              || (std == mrx_pkg::MRX_B103);
    is_tone = (std == mrx_pkg::MRX_TONE);
  end
endmodule // mrx_mode_dec

// *** mrx_pkg.sv ***
// package: receive command/status word layouts and register map
package mrx_pkg;
  // receive mode codes, first command byte bits 3:0
  localparam logic [3:0] MODE_OFF  = 4'h0;
  localparam logic [3:0] MODE_V22B = 4'h1;
  localparam logic [3:0] MODE_V22  = 4'h2;
  localparam logic [3:0] MODE_B212 = 4'h3;
  localparam logic [3:0] MODE_V23  = 4'h4;
  localparam logic [3:0] MODE_V21  = 4'h5;
  localparam logic [3:0] MODE_B103 = 4'h6;
  localparam logic [3:0] MODE_TONE = 4'h7;
  typedef enum {
    MRX_OFF, MRX_V22B, MRX_V22, MRX_B212, MRX_V23, MRX_V21, MRX_B103,
    MRX_TONE, MRX_BAD
  } mrx_std_type;
  // command byte field positions
  localparam int CMD_WORD_BIT  = 0;  // third byte bit 0: 1 = receive
  localparam int CMD_ANS_TONE  = 4;
  localparam int CMD_TX_SYNC   = 5;
  localparam int CMD_CD_LEVEL  = 6;
  localparam int CMD_ANS_ORIG  = 7;
  localparam int CMD_DESCR     = 5;
  localparam int CMD_BIN_RATE  = 7;
  localparam logic [7:0] CMD1_RSV_MASK = 8'h00;
  localparam logic [7:0] CMD2_RSV_MASK = 8'h5f;
  localparam logic [7:0] CMD3_RSV_MASK = 8'hfe;
  // status byte field positions
  localparam int STS_S1_BIT    = 7;
  localparam int STS_ANS_BIT   = 7;
  // register offsets
  localparam logic [3:0] REG_CMD1   = 4'h0;
  localparam logic [3:0] REG_CMD2   = 4'h1;
  localparam logic [3:0] REG_CMD3   = 4'h2;
  localparam logic [3:0] REG_STS1   = 4'h3;
  localparam logic [3:0] REG_STS2   = 4'h4;
  localparam logic [3:0] REG_STS3   = 4'h5;
  localparam logic [3:0] REG_IRQ_ST = 4'h6;
  localparam logic [3:0] REG_IRQ_EN = 4'h7;
  localparam logic [3:0] REG_IRQ_CL = 4'h8;
  localparam logic [3:0] REG_MODE   = 4'h9;
  // interrupt status bits
  localparam int IRQ_W       = 4;
  localparam int IRQ_S1      = 0;
  localparam int IRQ_CPT     = 1;
  localparam int IRQ_ANS     = 2;
  localparam int IRQ_RSV_ERR = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
endpackage

// *** mrx_top.sv ***
// receive command word decoder and receive status word assembler
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module mrx_top (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic [3:0] dp_data_raw,
  input  wire logic [5:0] dp_data_descr,
  input  wire logic [1:0] dp_raw_width,
  input  wire logic [2:0] dp_descr_width,
  input  wire logic       dp_s1_det,
  input  wire logic       dp_cpt_det,
  input  wire logic       dp_ans_det,
  input  wire logic       dp_eq_ok,
  input  wire logic       dp_sig_qual,
  input  wire logic       dp_carrier,
  output logic            rx_enable,
  output logic            tone_detect_mode,
  output logic            ans_tone_sel,
  output logic            tx_sync,
  output logic            cd_level,
  output logic            answer_mode,
  output logic            descr_on,
  output logic            binary_rate,
  output logic            irq
);
  logic [7:0]              cmd1_q;
  logic [7:0]              cmd2_q;
  logic [7:0]              cmd3_q;
  logic [7:0]              sts1_q;
  logic [7:0]              sts2_q;
  logic [7:0]              sts3_q;
  logic [mrx_pkg::IRQ_W-1:0] irq_st_q;
  logic [mrx_pkg::IRQ_W-1:0] irq_en_q;
  logic [mrx_pkg::IRQ_W-1:0] ev;
  logic [mrx_pkg::IRQ_W-1:0] clr;
  logic                    s1_q;
  logic                    cpt_q;
  logic                    ans_q;
  logic                    rsv_err;
  mrx_pkg::mrx_std_type    std;
  logic                    is_psk;
  logic                    is_fsk;
  logic                    is_tone;
  logic [7:0]              sts1_d;
  logic [7:0]              sts2_d;
  logic [7:0]              sts3_d;

  // fill unused data bits with ones above the valid width
  function automatic logic [5:0] ones_fill(input logic [5:0] d,
                                           input logic [2:0] w);
    logic [5:0] m;
    m = 6'h3f;
    if (w < 3'h6)
      m = 6'((7'h01 << w) - 7'h01);
    ones_fill = (d & m) | ~m;
  endfunction

  mrx_mode_dec u_dec (
    .mode_code (cmd1_q[3:0]),
    .std       (std),
    .is_psk    (is_psk),
    .is_fsk    (is_fsk),
    .is_tone   (is_tone)
  );

  // command bytes; every write is stored, whatever bit0 of the third byte holds
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd1_q <= mrx_pkg::RST_BYTE;
      cmd2_q <= mrx_pkg::RST_BYTE;
      cmd3_q <= mrx_pkg::RST_BYTE;
    end
    else if (wr_stb)
    begin
      case (addr)
        mrx_pkg::REG_CMD1: cmd1_q <= wdata;
        mrx_pkg::REG_CMD2: cmd2_q <= wdata;
        mrx_pkg::REG_CMD3: cmd3_q <= wdata;
        default: ;
      endcase
    end
  end

  // reserved bits set by the host are flagged, not acted on
  assign rsv_err = wr_stb && (
    ((addr == mrx_pkg::REG_CMD2) && |(wdata & mrx_pkg::CMD2_RSV_MASK)) ||
    ((addr == mrx_pkg::REG_CMD3) &&
     |(wdata & mrx_pkg::CMD3_RSV_MASK)));

  // option outputs; a transmit-marked word leaves the receiver idle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_enable        <= 1'b0;
      tone_detect_mode <= 1'b0;
      ans_tone_sel     <= 1'b0;
      tx_sync          <= 1'b0;
      cd_level         <= 1'b0;
      answer_mode      <= 1'b0;
      descr_on         <= 1'b0;
      binary_rate      <= 1'b0;
    end
    else
    begin
      rx_enable        <= cmd3_q[mrx_pkg::CMD_WORD_BIT] &&
                          (is_psk || is_fsk);
      tone_detect_mode <= cmd3_q[mrx_pkg::CMD_WORD_BIT] && is_tone;
      ans_tone_sel     <= cmd1_q[mrx_pkg::CMD_ANS_TONE];
      tx_sync          <= cmd1_q[mrx_pkg::CMD_TX_SYNC];
      cd_level         <= cmd1_q[mrx_pkg::CMD_CD_LEVEL];
      answer_mode      <= cmd1_q[mrx_pkg::CMD_ANS_ORIG];
      descr_on         <= cmd2_q[mrx_pkg::CMD_DESCR];
      binary_rate      <= cmd2_q[mrx_pkg::CMD_BIN_RATE];
    end
  end

  // status word assembly from datapump results
  always_comb
  begin
    sts1_d = 8'h01;
    sts2_d = 8'h00;
    sts3_d = 8'h00;
    // descrambled data sits in byte3; PSK keeps only four bits, the top two read one, FSK all six
    if (is_psk)
    begin
      sts1_d[4:1] = 4'(ones_fill({2'b11, dp_data_raw},
                                 {1'b0, dp_raw_width}));
      sts3_d[6:1] = ones_fill(dp_data_descr, dp_descr_width)
                    | 6'h30;
    end
    if (is_fsk)
      sts3_d[6:1] = dp_data_descr;
    sts1_d[mrx_pkg::STS_S1_BIT] = is_tone ? dp_cpt_det : dp_s1_det;
    sts1_d[6] = dp_s1_det && !is_tone;
    sts2_d[4] = dp_eq_ok;
    sts2_d[5] = dp_sig_qual;
    sts2_d[6] = dp_carrier;
    sts3_d[mrx_pkg::STS_ANS_BIT] = is_tone && dp_ans_det;
  end

  // status bytes latched every clock for a stable read
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sts1_q <= 8'h01;
      sts2_q <= mrx_pkg::RST_BYTE;
      sts3_q <= mrx_pkg::RST_BYTE;
    end
    else
    begin
      sts1_q <= sts1_d;
      sts2_q <= sts2_d;
      sts3_q <= sts3_d;
    end
  end

  // rising-edge detectors for the detection events
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q  <= 1'b0;
      cpt_q <= 1'b0;
      ans_q <= 1'b0;
    end
    else
    begin
      s1_q  <= dp_s1_det;
      cpt_q <= dp_cpt_det;
      ans_q <= dp_ans_det;
    end
  end

  always_comb
  begin
    ev = '0;
    ev[mrx_pkg::IRQ_S1]      = dp_s1_det && !s1_q && !is_tone;
    ev[mrx_pkg::IRQ_CPT]     = dp_cpt_det && !cpt_q && is_tone;
    ev[mrx_pkg::IRQ_ANS]     = dp_ans_det && !ans_q && is_tone;
    ev[mrx_pkg::IRQ_RSV_ERR] = rsv_err;
    clr = (wr_stb && addr == mrx_pkg::REG_IRQ_CL) ?
          wdata[mrx_pkg::IRQ_W-1:0] : '0;
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_st_q <= mrx_pkg::RST_IRQ;
    else
      irq_st_q <= (irq_st_q & ~clr) | ev;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_en_q <= mrx_pkg::RST_IRQ;
    else if (wr_stb && addr == mrx_pkg::REG_IRQ_EN)
      irq_en_q <= wdata[mrx_pkg::IRQ_W-1:0];
  end

  assign irq = |(irq_st_q & irq_en_q);

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd_stb)
    begin
      case (addr)
        mrx_pkg::REG_CMD1:   rdata <= cmd1_q;
        mrx_pkg::REG_CMD2:   rdata <= cmd2_q;
        mrx_pkg::REG_CMD3:   rdata <= cmd3_q;
        mrx_pkg::REG_STS1:   rdata <= sts1_q;
        mrx_pkg::REG_STS2:   rdata <= sts2_q;
        mrx_pkg::REG_STS3:   rdata <= sts3_q;
        mrx_pkg::REG_IRQ_ST: rdata <= {4'h0, irq_st_q};
        mrx_pkg::REG_IRQ_EN: rdata <= {4'h0, irq_en_q};
        mrx_pkg::REG_MODE:   rdata <= {4'h0, 4'(std)};
        default:             rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule // mrx_top

// *** mrx_top_tb.sv ***
// testbench: receive command decode, status assembly, interrupts
`timescale 1ns/1ns
module mrx_top_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr_stb, rd_stb;
  logic [3:0] raw = 4'h0;
  logic [5:0] dsc = 6'h00;
  logic [1:0] rw = 2'h0;
  logic [2:0] dw = 3'h0;
  logic s1 = 1'b0, cpt = 1'b0, ans = 1'b0, eq = 1'b0, sq = 1'b0, cd = 1'b0;
  logic rxe, tdm, ats, txs, cdl, ansm, dso, bnr, irq;
  int errors = 0;
  int check_count = 0;
  mrx_host_model host_u (.ref_clk(ref_clk), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  mrx_top dut_u (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .dp_data_raw(raw),
    .dp_data_descr(dsc), .dp_raw_width(rw), .dp_descr_width(dw),
    .dp_s1_det(s1), .dp_cpt_det(cpt), .dp_ans_det(ans), .dp_eq_ok(eq),
    .dp_sig_qual(sq), .dp_carrier(cd), .rx_enable(rxe),
    .tone_detect_mode(tdm), .ans_tone_sel(ats), .tx_sync(txs),
    .cd_level(cdl), .answer_mode(ansm), .descr_on(dso),
    .binary_rate(bnr), .irq(irq));
  // 125 MHz
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  // wide enough to hold a flag beside a full byte
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string s);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s %h/%h", $time, s, got, exp);
    end
  endtask
  // datapump levels, widths kept in the legal range
  task automatic dp_rand();
    {raw, dsc, rw, s1, cpt, ans, eq, sq, cd} <= 18'($urandom);
    dw <= 3'($urandom % 7);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard, far beyond the roughly 190 cycles of the tests
  initial
  begin
    #50000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    logic [7:0] d, e;
    logic [5:0] f;
    int m;
    int k;
    void'($urandom(18941));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    host_u.wr(4'h2, 8'h01, 1'b0);
    for (m = 0; m < 10; m++)
    begin
      e = 8'($urandom);
      e[3:0] = 4'(m);
      host_u.wr(4'h0, e, 1'b0);
      host_u.rd(4'h9, d);
      chk(d, (m > 8) ? 8'h08 : 8'(m), "mode");
      chk({ansm, cdl, txs, ats}, e[7:4], "opts");
      chk({tdm, rxe}, {m == 7, m > 0 && m < 7}, "enables");
    end
    repeat (4)
    begin
      e = 8'($urandom);
      host_u.wr(4'h1, e, 1'b0);
      host_u.rd(4'h1, d);
      chk(d, e & 8'ha0, "cmd2");
      chk({dso, bnr}, {e[5], e[7]}, "cmd2 opts");
    end
    $display("command decode done");
    host_u.wr(4'h0, 8'h01, 1'b0);
    repeat (8)
    begin
      @(posedge ref_clk);
      dp_rand();
      host_u.rd(4'h3, d);
      e = {s1, s1, 1'b0, raw | ~((4'h1 << rw) - 4'h1), 1'b1};
      chk(d & 8'hdf, e, "status1");
      host_u.rd(4'h4, d);
      chk(d, {1'b0, cd, sq, eq, 4'h0}, "status2");
      for (k = 0; k < 6; k++)
        f[k] = (k >= dw || k > 3) ? 1'b1 : dsc[k];
      host_u.rd(4'h5, d);
      chk(d, {1'b0, f, 1'b0}, "status3");
    end
    // frequency-shift modes hand the data over unfilled in byte3
    host_u.wr(4'h0, 8'h05, 1'b0);
    @(posedge ref_clk);
    dp_rand();
    host_u.rd(4'h5, d);
    chk(d, {1'b0, dsc, 1'b0}, "fsk data");
    $display("status done");
    host_u.wr(4'h8, 8'h0f, 1'b0);
    host_u.wr(4'h7, 8'h01, 1'b0);
    s1 <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(irq, 1'b0, "irq idle");
    @(posedge ref_clk);
    s1 <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(irq, 1'b1, "irq set");
    host_u.wr(4'h8, 8'h01, 1'b0);
    host_u.rd(4'h6, d);
    chk({irq, d[0]}, 2'b00, "irq clear");
    host_u.wr(4'h1, 8'h01, 1'b1);
    host_u.rd(4'h6, d);
    chk(d[3], 1'b1, "reserved flag");
    host_u.wr(4'h7, 8'h08, 1'b0);
    host_u.rd(4'hf, d);
    chk({irq, d}, 9'h100, "unmapped");
    host_u.wr(4'h7, 8'h00, 1'b0);
    $display("interrupts done");
    host_u.wr(4'h0, 8'h07, 1'b0);
    repeat (6)
    begin
      @(posedge ref_clk);
      dp_rand();
      host_u.rd(4'h3, d);
      host_u.rd(4'h5, e);
      chk({d[7], e[7]}, {cpt, ans}, "tone flags");
    end
    $display("tone done");
    tally_and_finish();
  end
endmodule // mrx_top_tb
